/* File: core/mao_consts.svh */
// Register offsets, control fields, attribute encodings and masks of the ordering agent
`ifndef MAO_CONSTS_SVH
`define MAO_CONSTS_SVH

// Register byte offsets
`define MAO_REG_CTRL         4'h0
`define MAO_REG_STATUS       4'h4
`define MAO_REG_FWD_CNT      4'h8
`define MAO_REG_MRG_CNT      4'hc

// Control fields and reset value
`define MAO_CTRL_POST_BIT    0
`define MAO_CTRL_MERGE_BIT   1
`define MAO_CTRL_FWD_BIT     2
`define MAO_CTRL_W           3
`define MAO_CTRL_RESET       3'h7

// Memory-type attribute encodings on the request port
`define MAO_ATTR_DEV_STRICT_ORDER_FINAL_COMPLETION    3'h0
`define MAO_ATTR_DEV_NRE     3'h1
`define MAO_ATTR_DEV_RE      3'h2
`define MAO_ATTR_NORM_NC     3'h3
`define MAO_ATTR_WB_NOALLOC  3'h4
`define MAO_ATTR_WB_ALLOC    3'h5

// Address and data layout
`define MAO_LINE_LSB         6
`define MAO_EXT_W            6
`define MAO_BE_W             8
`define MAO_DATA_W           64
`define MAO_BE_FULL          8'hff

`endif

/* File: core/mao_pkg.sv */
// Types and attribute decoding shared by the ordering agent
`include "mao_consts.svh"
package mao_pkg;

   typedef enum logic [2:0] {
      MAO_STRICT_ORDER_FINAL_COMPLETION,
      MAO_STRICT_ORDER_EARLY_COMPLETION,
      MAO_REORDERABLE_EARLY_COMPLETION,
      MAO_NORMAL_NONCACHEABLE,
      MAO_WRITEBACK_NO_ALLOC_HINT,
      MAO_WRITEBACK_ALLOC_HINT
   } mao_class_t;

   typedef enum logic [2:0] {
      MAO_ST_IDLE,
      MAO_ST_FWD,
      MAO_ST_DRD,
      MAO_ST_DREQ,
      MAO_ST_DWAIT
   } mao_state_t;

   // Unknown encodings fall back to the strictest type
   function automatic mao_class_t mao_decode(input logic [2:0] attr);
      case (attr)
         `MAO_ATTR_DEV_NRE:     return MAO_STRICT_ORDER_EARLY_COMPLETION;
         `MAO_ATTR_DEV_RE:      return MAO_REORDERABLE_EARLY_COMPLETION;
         `MAO_ATTR_NORM_NC:     return MAO_NORMAL_NONCACHEABLE;
         `MAO_ATTR_WB_NOALLOC:  return MAO_WRITEBACK_NO_ALLOC_HINT;
         `MAO_ATTR_WB_ALLOC:    return MAO_WRITEBACK_ALLOC_HINT;
         default:               return MAO_STRICT_ORDER_FINAL_COMPLETION;
      endcase
   endfunction

   function automatic logic mao_is_device(input mao_class_t c);
      return (c == MAO_STRICT_ORDER_FINAL_COMPLETION) || (c == MAO_STRICT_ORDER_EARLY_COMPLETION) ||
             (c == MAO_REORDERABLE_EARLY_COMPLETION);
   endfunction

endpackage

/* File: core/mao_wbuf_mem.sv */
// Data store of the posted-write buffer, byte-strobed write, registered read
`timescale 1ns/1ns
`include "mao_consts.svh"
module mao_wbuf_mem
   #(
   parameter int DEPTH = 4,
   parameter int IDX_W = 2
   )
   (
   // Clock and reset
   input  wire logic                   clk_sys_i,
   input  wire logic                   reset_n_i,
   // Write port
   input  wire logic                   we_i,
   input  wire logic [IDX_W-1:0]       waddr_i,
   input  wire logic [`MAO_BE_W-1:0]   wstrb_i,
   input  wire logic [`MAO_DATA_W-1:0] wdata_i,
   // Read port
   input  wire logic [IDX_W-1:0]       raddr_i,
   output logic      [`MAO_DATA_W-1:0] rdata_o
   );

   logic [`MAO_DATA_W-1:0] mem_q [DEPTH];

   always_ff @(posedge clk_sys_i)
   begin
      for (int b = 0; b < `MAO_BE_W; b++)
      begin
         if (we_i && wstrb_i[b])
            mem_q[waddr_i][b*8 +: 8] <= wdata_i[b*8 +: 8];
      end
   end

   // Read-before-write: a same-cycle write is seen one cycle later
   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         rdata_o <= '0;
      else
         rdata_o <= mem_q[raddr_i];
   end

endmodule

/* File: core/mao_regs.sv */
// Avalon-MM register slave: control bits, buffer status and event counters
`timescale 1ns/1ns
`include "mao_consts.svh"
module mao_regs
   (
   // Clock and reset
   input  wire logic                   clk_sys_i,
   input  wire logic                   reset_n_i,
   // Avalon-MM slave
   input  wire logic [3:0]             avs_address_i,
   input  wire logic                   avs_read_i,
   input  wire logic                   avs_write_i,
   input  wire logic [3:0]             avs_byteenable_i,
   input  wire logic [31:0]            avs_writedata_i,
   output logic      [31:0]            avs_readdata_o,
   output logic                        avs_waitrequest_o,
   // Block side
   output logic      [`MAO_CTRL_W-1:0] ctrl_o,
   input  wire logic [7:0]             buf_cnt_i,
   input  wire logic                   busy_i,
   input  wire logic [31:0]            fwd_cnt_i,
   input  wire logic [31:0]            mrg_cnt_i
   );

   logic        ack_q;
   wire         access = avs_read_i | avs_write_i;
   wire         sel_ctrl = (avs_address_i == `MAO_REG_CTRL);
   wire         sel_stat = (avs_address_i == `MAO_REG_STATUS);
   wire         sel_fwd = (avs_address_i == `MAO_REG_FWD_CNT);
   wire         sel_mrg = (avs_address_i == `MAO_REG_MRG_CNT);
   wire [31:0]  rd_mux = sel_ctrl ? {29'h0, ctrl_o} :
                         sel_stat ? {23'h0, busy_i, buf_cnt_i} :
                         sel_fwd  ? fwd_cnt_i :
                         sel_mrg  ? mrg_cnt_i : 32'h0;
   wire         ctrl_wr = avs_write_i & ack_q & sel_ctrl & avs_byteenable_i[0];

   // Every access waits exactly one cycle; unmapped reads return zero
   assign avs_waitrequest_o = access & ~ack_q;

   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         ack_q <= 1'b0;
      else
         ack_q <= access & ~ack_q;
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         avs_readdata_o <= 32'h0;
      else if (avs_read_i && !ack_q)
         avs_readdata_o <= rd_mux;
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         ctrl_o <= `MAO_CTRL_RESET;
      else if (ctrl_wr)
         ctrl_o <= avs_writedata_i[`MAO_CTRL_W-1:0];
   end

endmodule

/* File: core/mao_agent.sv */
// Memory attribute ordering agent: posting, forwarding and merging by memory type
`timescale 1ns/1ns
`include "mao_consts.svh"
module mao_agent
   import mao_pkg::*;
   #(
   parameter int ADDR_W = 48,
   parameter int PHYS_W = 44,
   parameter int DEPTH  = 4
   )
   (
   // Clock and reset
   input  wire logic                   clk_sys_i,
   input  wire logic                   reset_n_i,
   // Request from the requester
   input  wire logic                   req_valid_i,
   output logic                        req_ready_o,
   input  wire logic                   req_write_i,
   input  wire logic [ADDR_W-1:0]      req_addr_i,
   input  wire logic                   req_ext_vld_i,
   input  wire logic [`MAO_EXT_W-1:0]  req_ext_addr_i,
   input  wire logic [2:0]             req_attr_i,
   input  wire logic [2:0]             req_size_i,
   input  wire logic                   req_security_state_bit_i,
   input  wire logic [`MAO_BE_W-1:0]   req_be_i,
   input  wire logic [`MAO_DATA_W-1:0] req_data_i,
   // Response to the requester
   output logic                        rsp_valid_o,
   output logic                        rsp_write_o,
   output logic      [`MAO_DATA_W-1:0] rsp_data_o,
   // Snoop lookup
   input  wire logic                   snp_valid_i,
   input  wire logic [ADDR_W-1:0]      snp_addr_i,
   input  wire logic                   snp_security_state_bit_i,
   output logic                        snp_rsp_valid_o,
   output logic                        snp_hit_o,
   // Request to the endpoint
   output logic                        dn_valid_o,
   input  wire logic                   dn_ready_i,
   output logic                        dn_write_o,
   output logic      [ADDR_W-1:0]      dn_addr_o,
   output logic      [2:0]             dn_size_o,
   output logic      [2:0]             dn_class_o,
   output logic                        dn_alloc_o,
   output logic                        dn_security_state_bit_o,
   output logic      [`MAO_BE_W-1:0]   dn_be_o,
   output logic      [`MAO_DATA_W-1:0] dn_data_o,
   // Endpoint response
   input  wire logic                   dn_rsp_valid_i,
   input  wire logic [`MAO_DATA_W-1:0] dn_rsp_data_i,
   // Avalon-MM register slave
   input  wire logic [3:0]             avs_address_i,
   input  wire logic                   avs_read_i,
   input  wire logic                   avs_write_i,
   input  wire logic [3:0]             avs_byteenable_i,
   input  wire logic [31:0]            avs_writedata_i,
   output logic      [31:0]            avs_readdata_o,
   output logic                        avs_waitrequest_o
   );

   localparam int IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = IDX_W + 1;

   function automatic logic line_match(input logic [ADDR_W-1:0] a, input logic sa,
                                       input logic [ADDR_W-1:0] b, input logic sb);
      return (a[ADDR_W-1:`MAO_LINE_LSB] == b[ADDR_W-1:`MAO_LINE_LSB]) && (sa == sb);
   endfunction

   // State
   mao_state_t             st_q;
   mao_state_t             st_d;
   logic [`MAO_CTRL_W-1:0] ctrl;
   logic [IDX_W-1:0]       head_q;
   logic [IDX_W-1:0]       tail_q;
   logic [CNT_W-1:0]       cnt_q;
   logic [31:0]            fwd_cnt_q;
   logic [31:0]            mrg_cnt_q;
   logic [`MAO_DATA_W-1:0] mem_rdata;

   // Buffer tags, valid between head and tail
   logic [ADDR_W-1:0]      tag_addr_q [DEPTH];
   logic [2:0]             tag_size_q [DEPTH];
   logic                   tag_sec_q  [DEPTH];
   logic [`MAO_BE_W-1:0]   tag_be_q   [DEPTH];
   mao_class_t             tag_cls_q  [DEPTH];

   // Transaction held for the endpoint
   logic                   drain_q;
   logic                   cur_write_q;
   mao_class_t             cur_cls_q;

   // Request decode
   wire [ADDR_W-1:0] phys_mask = {{(ADDR_W-PHYS_W){1'b0}}, {PHYS_W{1'b1}}};
   wire [ADDR_W-1:0] raw_addr = req_ext_vld_i ? {req_addr_i[ADDR_W-1:`MAO_LINE_LSB], req_ext_addr_i}
                                              : req_addr_i;
   wire [ADDR_W-1:0] eff_addr = raw_addr & phys_mask;
   wire mao_class_t  req_cls = mao_decode(req_attr_i);
   wire              req_dev = mao_is_device(req_cls);
   wire              st_idle = (st_q == MAO_ST_IDLE);
   wire              empty = (cnt_q == '0);
   wire              full = (cnt_q == CNT_W'(DEPTH));
   wire [IDX_W-1:0]  last_idx = tail_q - 1'b1;

   // Buffer lookup: oldest to newest so the newest overlapping entry decides
   logic             ovl_any;
   logic             fwd_hit;
   logic [IDX_W-1:0] fwd_idx;
   logic             snp_any;
   logic [IDX_W-1:0] lk_idx;

   always_comb
   begin
      lk_idx  = '0;
      ovl_any = 1'b0;
      fwd_hit = 1'b0;
      fwd_idx = '0;
      snp_any = 1'b0;
      for (int i = 0; i < DEPTH; i++)
      begin
         lk_idx = head_q + IDX_W'(i);
         if (CNT_W'(i) < cnt_q)
         begin
            if (line_match(tag_addr_q[lk_idx], tag_sec_q[lk_idx], eff_addr, req_security_state_bit_i))
            begin
               ovl_any = 1'b1;
               // A newer partial write over the same line cancels an older exact hit
               fwd_hit = (tag_addr_q[lk_idx] == eff_addr) && (tag_size_q[lk_idx] == req_size_i) &&
                         (tag_be_q[lk_idx] == `MAO_BE_FULL);
               fwd_idx = lk_idx;
            end
            if (line_match(tag_addr_q[lk_idx], tag_sec_q[lk_idx], snp_addr_i & phys_mask,
                           snp_security_state_bit_i))
               snp_any = 1'b1;
         end
      end
   end

   // Policy decisions
   wire post_ok = ctrl[`MAO_CTRL_POST_BIT] &&
                  (req_cls != MAO_STRICT_ORDER_FINAL_COMPLETION);
   wire merge_hit = ctrl[`MAO_CTRL_MERGE_BIT] && !empty && !req_dev &&
                    !mao_is_device(tag_cls_q[last_idx]) && (tag_addr_q[last_idx] == eff_addr) &&
                    (tag_size_q[last_idx] == req_size_i) &&
                    (tag_sec_q[last_idx] == req_security_state_bit_i);
   wire reorder_ok = !req_dev || (req_cls == MAO_REORDERABLE_EARLY_COMPLETION);
   wire wr_merge = req_valid_i && req_write_i && post_ok && merge_hit;
   wire wr_push = req_valid_i && req_write_i && post_ok && !merge_hit && !full;
   wire wr_direct = req_valid_i && req_write_i && !post_ok && empty;
   wire rd_fwd = req_valid_i && !req_write_i && !req_dev &&
                 ctrl[`MAO_CTRL_FWD_BIT] && fwd_hit;
   wire rd_direct = req_valid_i && !req_write_i && !rd_fwd &&
                    (empty || (reorder_ok && !ovl_any));
   wire take = st_idle && (wr_merge || wr_push || wr_direct || rd_fwd || rd_direct);
   // Posted writes drain whenever the request cannot be absorbed
   wire drain_go = st_idle && !take && !empty;
   wire post_take = take && (wr_merge || wr_push);
   wire load_req = take && (wr_direct || rd_direct);
   wire load_drain = (st_q == MAO_ST_DRD);
   wire dn_done = (st_q == MAO_ST_DWAIT) && dn_rsp_valid_i;
   wire pop = dn_done && drain_q;
   wire rsp_fire = post_take || (st_q == MAO_ST_FWD) || (dn_done && !drain_q);

   assign req_ready_o = take;
   assign dn_valid_o = (st_q == MAO_ST_DREQ);

   always_comb
   begin
      st_d = st_q;
      case (st_q)
         MAO_ST_IDLE:
         begin
            if (take && rd_fwd)
               st_d = MAO_ST_FWD;
            else if (load_req)
               st_d = MAO_ST_DREQ;
            else if (drain_go)
               st_d = MAO_ST_DRD;
         end
         MAO_ST_FWD:
            st_d = MAO_ST_IDLE;
         MAO_ST_DRD:
            st_d = MAO_ST_DREQ;
         MAO_ST_DREQ:
         begin
            if (dn_ready_i)
               st_d = MAO_ST_DWAIT;
         end
         MAO_ST_DWAIT:
         begin
            if (dn_rsp_valid_i)
               st_d = MAO_ST_IDLE;
         end
         default:
            st_d = MAO_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         st_q <= MAO_ST_IDLE;
      else
         st_q <= st_d;
   end

   // Buffer pointers; push and pop never coincide since pop happens outside idle
   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         head_q <= '0;
         tail_q <= '0;
         cnt_q  <= '0;
      end
      else
      begin
         if (take && wr_push)
            tail_q <= tail_q + 1'b1;
         if (pop)
            head_q <= head_q + 1'b1;
         cnt_q <= cnt_q + CNT_W'(take && wr_push) - CNT_W'(pop);
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (take && wr_push)
      begin
         tag_addr_q[tail_q] <= eff_addr;
         tag_size_q[tail_q] <= req_size_i;
         tag_sec_q[tail_q]  <= req_security_state_bit_i;
         tag_be_q[tail_q]   <= req_be_i;
         tag_cls_q[tail_q]  <= req_cls;
      end
      else if (take && wr_merge)
         tag_be_q[last_idx] <= tag_be_q[last_idx] | req_be_i;
   end

   mao_wbuf_mem #(
      .DEPTH     (DEPTH),
      .IDX_W     (IDX_W)
   ) u_mem (
      .clk_sys_i (clk_sys_i),
      .reset_n_i (reset_n_i),
      .we_i      (post_take),
      .waddr_i   (wr_merge ? last_idx : tail_q),
      .wstrb_i   (req_be_i),
      .wdata_i   (req_data_i),
      .raddr_i   (rd_fwd ? fwd_idx : head_q),
      .rdata_o   (mem_rdata)
   );

   // Endpoint request carries the exact address and size, never widened
   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         drain_q     <= 1'b0;
         cur_write_q <= 1'b0;
         cur_cls_q   <= MAO_STRICT_ORDER_FINAL_COMPLETION;
         dn_addr_o   <= '0;
         dn_size_o   <= '0;
         dn_security_state_bit_o <= 1'b0;
         dn_be_o     <= '0;
         dn_data_o   <= '0;
         dn_alloc_o  <= 1'b0;
      end
      else if (load_drain)
      begin
         drain_q     <= 1'b1;
         cur_write_q <= 1'b1;
         cur_cls_q   <= tag_cls_q[head_q];
         dn_addr_o   <= tag_addr_q[head_q];
         dn_size_o   <= tag_size_q[head_q];
         dn_security_state_bit_o <= tag_sec_q[head_q];
         dn_be_o     <= tag_be_q[head_q];
         dn_data_o   <= mem_rdata;
         dn_alloc_o  <= (tag_cls_q[head_q] == MAO_WRITEBACK_ALLOC_HINT);
      end
      else if (load_req)
      begin
         drain_q     <= 1'b0;
         cur_write_q <= req_write_i;
         cur_cls_q   <= req_cls;
         dn_addr_o   <= eff_addr;
         dn_size_o   <= req_size_i;
         dn_security_state_bit_o <= req_security_state_bit_i;
         dn_be_o     <= req_be_i;
         dn_data_o   <= req_data_i;
         dn_alloc_o  <= (req_cls == MAO_WRITEBACK_ALLOC_HINT);
      end
   end

   assign dn_write_o = cur_write_q;
   assign dn_class_o = cur_cls_q;

   // Forwarded data goes straight out and is never kept for a later read
   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         rsp_valid_o <= 1'b0;
         rsp_write_o <= 1'b0;
         rsp_data_o  <= '0;
      end
      else
      begin
         rsp_valid_o <= rsp_fire;
         if (rsp_fire)
         begin
            rsp_write_o <= post_take || (dn_done && cur_write_q);
            rsp_data_o  <= (st_q == MAO_ST_FWD) ? mem_rdata : dn_rsp_data_i;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         snp_rsp_valid_o <= 1'b0;
         snp_hit_o       <= 1'b0;
         fwd_cnt_q       <= '0;
         mrg_cnt_q       <= '0;
      end
      else
      begin
         snp_rsp_valid_o <= snp_valid_i;
         snp_hit_o       <= snp_valid_i && snp_any;
         fwd_cnt_q       <= fwd_cnt_q + 32'(take && rd_fwd);
         mrg_cnt_q       <= mrg_cnt_q + 32'(take && wr_merge);
      end
   end

   mao_regs u_regs (
      .clk_sys_i         (clk_sys_i),
      .reset_n_i         (reset_n_i),
      .avs_address_i     (avs_address_i),
      .avs_read_i        (avs_read_i),
      .avs_write_i       (avs_write_i),
      .avs_byteenable_i  (avs_byteenable_i),
      .avs_writedata_i   (avs_writedata_i),
      .avs_readdata_o    (avs_readdata_o),
      .avs_waitrequest_o (avs_waitrequest_o),
      .ctrl_o            (ctrl),
      .buf_cnt_i         (8'(cnt_q)),
      .busy_i            (!st_idle),
      .fwd_cnt_i         (fwd_cnt_q),
      .mrg_cnt_i         (mrg_cnt_q)
   );

endmodule

/* File: tb/mao_agent_sva.sv */
// Port-level assertion checker for the ordering agent
`timescale 1ns/1ns
module mao_agent_sva
   #(
   parameter int ADDR_W = 48,
   parameter int PHYS_W = 44
   )
   (
   // Clock and reset
   input wire logic              clk_sys_i,
   input wire logic              reset_n_i,
   // Watched ports
   input wire logic              req_valid_i,
   input wire logic              req_ready_o,
   input wire logic              req_write_i,
   input wire logic [2:0]        req_attr_i,
   input wire logic              snp_valid_i,
   input wire logic              snp_rsp_valid_o,
   input wire logic              dn_valid_o,
   input wire logic              dn_ready_i,
   input wire logic              dn_write_o,
   input wire logic [ADDR_W-1:0] dn_addr_o,
   input wire logic [2:0]        dn_class_o,
   input wire logic              dn_alloc_o,
   input wire logic              avs_read_i,
   input wire logic              avs_write_i,
   input wire logic              avs_waitrequest_o
   );
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);
   a_addr_upper_zero: assert property (dn_valid_o |-> dn_addr_o[ADDR_W-1:PHYS_W] == '0)
      else $error("upper address bits set");
   a_dn_req_hold: assert property (dn_valid_o && !dn_ready_i |=> dn_valid_o && $stable(dn_addr_o))
      else $error("endpoint request changed");
   a_snoop_answer: assert property (snp_valid_i |=> snp_rsp_valid_o)
      else $error("snoop not answered");
   a_alloc_hint: assert property (dn_valid_o |-> dn_alloc_o == (dn_class_o == 3'h5))
      else $error("wrong allocation hint");
   a_class_range: assert property (dn_valid_o |-> dn_class_o <= 3'h5)
      else $error("bad memory class");
   a_ready_idle: assert property (req_ready_o |-> !dn_valid_o)
      else $error("request taken while endpoint busy");
   a_dev_read_ep: assert property (req_valid_i && req_ready_o && !req_write_i && req_attr_i <= 3'h2
      |=> dn_valid_o && !dn_write_o && dn_class_o == $past(req_attr_i))
      else $error("device read not sent to endpoint");
   a_bus_one_wait: assert property ($rose(avs_read_i || avs_write_i)
      |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("register access wait wrong");
endmodule
bind mao_agent mao_agent_sva #(.ADDR_W(ADDR_W), .PHYS_W(PHYS_W)) u_sva (.clk_sys_i, .reset_n_i,
   .req_valid_i, .req_ready_o, .req_write_i, .req_attr_i, .snp_valid_i, .snp_rsp_valid_o, .dn_valid_o,
   .dn_ready_i, .dn_write_o, .dn_addr_o, .dn_class_o, .dn_alloc_o, .avs_read_i, .avs_write_i,
   .avs_waitrequest_o);

/* File: tb/mao_ep_model.sv */
// Endpoint model: accepts promptly or slowly and answers every request once
`timescale 1ns/1ns
module mao_ep_model
   (
   // Clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        reset_n_i,
   // Request side
   input  wire logic        slow_i,
   input  wire logic        dn_valid_i,
   input  wire logic        dn_write_i,
   input  wire logic [47:0] dn_addr_i,
   output logic             dn_ready_o,
   output logic             dn_rsp_valid_o,
   output logic      [63:0] dn_rsp_data_o
   );
   logic [2:0] wait_q;
   // Slow mode keeps posted data in the buffer long enough to snoop it
   assign dn_ready_o = dn_valid_i && (!slow_i || wait_q == 3'h7);
   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         wait_q <= 3'h0;
         dn_rsp_valid_o <= 1'b0;
         dn_rsp_data_o <= 64'h0;
      end
      else
      begin
         wait_q <= (dn_valid_i && !dn_ready_o) ? wait_q + 3'h1 : 3'h0;
         dn_rsp_valid_o <= dn_ready_o;
         // Idle data toggles so a stale value is never mistaken for an answer
         dn_rsp_data_o <= (dn_ready_o && !dn_write_i) ? {16'h0, dn_addr_i} : ~dn_rsp_data_o;
      end
   end
endmodule

/* File: tb/tb_top.sv */
// Directed testbench for the ordering agent
`timescale 1ns/1ns
module tb_top;
   logic        clk_sys_i, reset_n_i, req_valid_i, req_ready_o, req_write_i, req_security_state_bit_i, slow;
   logic        rsp_valid_o, rsp_write_o, snp_valid_i, snp_security_state_bit_i, snp_rsp_valid_o, snp_hit_o;
   logic        dn_valid_o, dn_ready_i, dn_write_o, dn_alloc_o, dn_rsp_valid_i;
   logic        avs_read_i, avs_write_i, avs_waitrequest_o;
   logic [2:0]  req_attr_i, dn_class_o;
   logic [3:0]  avs_address_i;
   logic [31:0] avs_writedata_i, avs_readdata_o, w;
   logic [47:0] req_addr_i, snp_addr_i, dn_addr_o;
   logic [63:0] req_data_i, rsp_data_o, dn_rsp_data_i, q, dn_data_o, wd;
   logic [1:0]  h;
   logic [5:0]  ext_a;
   logic        wr, ext_v;
   int          fails, n_tests;
   mao_agent DUT (.clk_sys_i, .reset_n_i, .req_valid_i, .req_ready_o, .req_write_i, .req_addr_i,
      .req_ext_vld_i(ext_v), .req_ext_addr_i(ext_a), .req_attr_i, .req_size_i(3'h3), .req_security_state_bit_i,
      .req_be_i(8'hff), .req_data_i, .rsp_valid_o, .rsp_write_o, .rsp_data_o, .snp_valid_i, .snp_addr_i,
      .snp_security_state_bit_i, .snp_rsp_valid_o, .snp_hit_o, .dn_valid_o, .dn_ready_i, .dn_write_o,
      .dn_addr_o, .dn_size_o(), .dn_class_o, .dn_alloc_o, .dn_security_state_bit_o(), .dn_be_o(),
      .dn_data_o, .dn_rsp_valid_i, .dn_rsp_data_i, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_byteenable_i(4'hf), .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o);
   mao_ep_model EP (.clk_sys_i, .reset_n_i, .slow_i(slow), .dn_valid_i(dn_valid_o), .dn_write_i(dn_write_o),
      .dn_addr_i(dn_addr_o), .dn_ready_o(dn_ready_i), .dn_rsp_valid_o(dn_rsp_valid_i), .dn_rsp_data_o(dn_rsp_data_i));
   initial
   begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   // Last write data handed to the endpoint
   always @(posedge clk_sys_i)
   begin
      if (dn_valid_o && dn_ready_i && dn_write_o)
         wd <= dn_data_o;
   end
   task automatic end_of_test;
      $display("Comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic avs(input logic wi, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
      avs_write_i <= wi;
      avs_read_i <= !wi;
      avs_address_i <= a;
      avs_writedata_i <= d;
      do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
      r = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   // Request stays raised on return so posted writes can follow back to back
   task automatic rq(input logic wi, input logic [47:0] a, input logic [2:0] at, input logic [63:0] d);
      req_valid_i <= 1'b1;
      req_write_i <= wi;
      req_addr_i <= a;
      req_attr_i <= at;
      req_data_i <= d;
      do @(posedge clk_sys_i); while (req_ready_o !== 1'b1);
   endtask
   task automatic rsp(output logic [63:0] r, output logic rw);
      req_valid_i <= 1'b0;
      do @(posedge clk_sys_i); while (rsp_valid_o !== 1'b1);
      r = rsp_data_o;
      rw = rsp_write_o;
   endtask
   task automatic snp(input logic [47:0] a, input logic sb, output logic [1:0] r);
      snp_valid_i <= 1'b1;
      snp_addr_i <= a;
      snp_security_state_bit_i <= sb;
      @(posedge clk_sys_i);
      snp_valid_i <= 1'b0;
      @(posedge clk_sys_i);
      r = {snp_rsp_valid_o, snp_hit_o};
   endtask
   initial
   begin
      #100000;
      fails++;
      end_of_test();
   end
   initial
   begin
      {reset_n_i, req_valid_i, req_write_i, req_security_state_bit_i, slow, snp_valid_i} = 0;
      {snp_security_state_bit_i, avs_read_i, avs_write_i, req_attr_i, avs_address_i} = 0;
      {avs_writedata_i, req_addr_i, snp_addr_i, req_data_i, ext_v, ext_a} = 0;
      repeat (6) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      avs(0, 4'h0, 0, w); chk(w, 3'h7);
      avs(1, 4'h0, 32'h3, w); avs(0, 4'h0, 0, w); chk(w, 3'h3);
      avs(1, 4'h0, 32'h7, w); avs(1, 4'h2, 32'h5, w); avs(0, 4'h2, 0, w); chk(w, 0);
      rq(0, 48'hf000_0000_1040, 3'h0, 0); rsp(q, wr); chk(q, 64'h1040);
      ext_v <= 1'b1; ext_a <= 6'h08; rq(0, 48'h6000, 3'h0, 0); rsp(q, wr); ext_v <= 1'b0; chk(q, 64'h6008);
      rq(1, 48'h2000, 3'h3, 64'h1111);
      rq(1, 48'h2000, 3'h3, 64'h2222);
      rq(0, 48'h2000, 3'h3, 0); rsp(q, wr); chk(q, 64'h2222);
      avs(0, 4'hc, 0, w); chk(w, 1);
      avs(0, 4'h8, 0, w); chk(w, 1);
      chk(wd, 64'h2222);
      rq(1, 48'h3000, 3'h1, 64'h5555);
      rq(0, 48'h3000, 3'h1, 0); rsp(q, wr); chk(q, 64'h3000);
      chk(wd, 64'h5555);
      rq(1, 48'h7000, 3'h2, 64'h7777);
      rq(0, 48'h8000, 3'h2, 0); rsp(q, wr); chk(q, 64'h8000);
      rq(0, 48'h7000, 3'h2, 0); rsp(q, wr); chk(q, 64'h7000);
      slow <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         rq(1, 48'h4000 + 48'(64 * i), i[2:0], 64'h0); rsp(q, wr); chk(wr, 1'b1);
      end
      rq(1, 48'h5000, 3'h3, 64'h9); rsp(q, wr);
      snp(48'h5008, 1'b0, h); chk(h, 2'b11);
      snp(48'h5008, 1'b1, h); chk(h, 2'b10);
      avs(0, 4'h4, 0, w); chk(w, 32'h101);
      repeat (40) @(posedge clk_sys_i);
      end_of_test();
   end
endmodule
